// ---- core/uie_pkg.sv ----
// package for the serial port interrupt enable / identification block
// assumes a 32-bit classic wishbone slave on the peripheral clock
package uie_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] IER_ADDR = 32'he0010004;
  localparam logic [31:0] IIR_ADDR = 32'he0010008;
  localparam logic [31:0] EVT_ADDR = 32'he0010040;
  localparam logic [31:0] EMASK_ADDR = 32'he0010044;

  // ==========================================================
  // field positions and reset values
  localparam int IER_DAV_BIT = 0;
  localparam int IER_TXE_BIT = 1;
  localparam int IER_LERR_BIT = 2;
  localparam int IER_MODEM_BIT = 3;
  localparam int IER_W = 4;
  localparam logic [IER_W-1:0] IER_RST = 4'h0;

  localparam logic [2:0] IIR_LERR = 3'h3;
  localparam logic [2:0] IIR_DAV = 3'h2;
  localparam logic [2:0] IIR_TMO = 3'h6;
  localparam logic [2:0] IIR_TXE = 3'h1;
  localparam logic [2:0] IIR_MODEM = 3'h0;
  localparam logic [3:0] IIR_SNAP_RST = 4'h1;

  localparam int EVT_LERR = 0;
  localparam int EVT_DAV = 1;
  localparam int EVT_TMO = 2;
  localparam int EVT_TXE = 3;
  localparam int EVT_MODEM = 4;
  localparam int EVT_W = 5;
  localparam logic [EVT_W-1:0] EVT_RST = 5'h00;
  localparam logic [EVT_W-1:0] EMASK_RST = 5'h00;

  // ==========================================================
  // timing, in receive clock ticks (16x baud enables)
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CTO_WL_MUL = 12'h007;
  localparam logic [CNT_W-1:0] CTO_WL_SUB = 12'h002;
  localparam logic [CNT_W-1:0] CTO_SCALE = 12'h008;
  localparam logic [CNT_W-1:0] CTO_ADD = 12'h001;
  localparam logic [CNT_W-1:0] RCLK_PER_BIT = 12'h010;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } uie_wb_req_s;

  typedef struct packed {
    logic overrun;
    logic parity_error;
    logic framing_error;
    logic break_detected;
  } uie_lerr_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } uie_modem_s;

  typedef struct packed {
    uie_modem_s msync1;
    uie_modem_s msync2;
    uie_modem_s mprev;
    logic [1:0] mvalid;
    logic [IER_W-1:0] ier;
    logic line_err;
    logic tmo;
    logic [CNT_W-1:0] cto_cnt;
    logic txe_irq;
    logic txe_done;
    logic seen2;
    logic [CNT_W-1:0] txe_cnt;
    logic modem_irq;
    logic dav_prev;
    logic [3:0] snap;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] emask;
    logic ack;
    logic [7:0] dat;
  } uie_state_s;

  localparam uie_state_s STATE_RST = '{ier: IER_RST, snap: IIR_SNAP_RST, evt: EVT_RST,
                                       emask: EMASK_RST, default: '0};

endpackage

// ---- core/uie_irq_ident.sv ----
// interrupt enable and identification logic of the serial port
// assumes receiver, transmitter and fifo logic on the same clock supply
// strobes and levels; modem pins arrive asynchronously
//
// Notes on behaviour
// - enable bit 0 gates data-available and character time-out interrupts
// - enable bit 1 gates the transmit holding empty interrupt
// - enable bit 2 gates receive line status error interrupts
// - enable bit 3 gates the modem status interrupt
// - enable bits 7:4 reserved; software writes zeros, reads zero
// - identify bit 0 reads 0 when enabled interrupt pending, resets to 1
// - identify bits 3:1 encode source: 011, 010, 110, 001, 000
// - priority: line error, then data/timeout, then transmit empty, then modem
// - identify bits 7:6 mirror fifo enable; 5:4 reserved; read-only
// - identify state frozen during its read; new interrupts reported next read
// - line error raised by overrun/parity/framing/break, cleared by status read
// - data available while receive fill at or above trigger level, or non-zero with fifo off
// - time-out when fifo non-empty and idle for 3.5 to 4.5 characters
// - any receive fifo read or write clears time-out and restarts timing
// - transmit empty clears on write or identify read showing it; immediate after two held
// - modem interrupt on dcd/dsr/cts change or ri rise, cleared by status read
// - time-out period ((wl*7-2)*8 + (trig-count)*8 + 1) receive ticks
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
module uie_irq_ident #(
  parameter int FIFO_CNT_W = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire uie_pkg::uie_wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic divisor_access_select_i,
  input wire logic fifo_en_i,
  input wire uie_pkg::uie_lerr_s line_err_i,
  input wire logic line_status_rd_i,
  input wire uie_pkg::uie_modem_s modem_pins_i,
  input wire logic modem_status_rd_i,
  input wire logic [FIFO_CNT_W-1:0] rx_count_i,
  input wire logic [FIFO_CNT_W-1:0] rx_trig_level_i,
  input wire logic rx_wr_i,
  input wire logic rx_rd_i,
  input wire logic rclk_tick_i,
  input wire logic [3:0] word_len_i,
  input wire logic tx_empty_i,
  input wire logic tx_held_two_i,
  input wire logic thr_wr_i,
  output logic irq_o,
  output logic evt_irq_o
);
  import uie_pkg::*;

  uie_state_s q;
  uie_state_s d;

  logic req;
  logic rd;
  logic wr;
  logic sel_ier;
  logic sel_iir;
  logic sel_evt;
  logic sel_msk;
  logic iir_busy;
  logic iir_rd;
  logic dav_lvl;
  logic act;
  logic mchg;
  logic [4:0] pend;
  logic [3:0] live;
  logic [CNT_W-1:0] cto_period;
  logic [CNT_W-1:0] txe_period;
  logic [CNT_W-1:0] trig_gap;
  logic [EVT_W-1:0] evt_set;
  logic [7:0] rdat;
  logic tmo_set;
  logic txe_set;

  // ==========================================================
  // bus decode
  always_comb begin
    req = wb_i.cyc & wb_i.stb & ~q.ack;
    rd = req & ~wb_i.we;
    wr = req & wb_i.we & wb_i.sel[0];
    // divisor latch shares this address while its select is set
    sel_ier = (wb_i.adr == IER_ADDR) & ~divisor_access_select_i;
    sel_iir = wb_i.adr == IIR_ADDR;
    sel_evt = wb_i.adr == EVT_ADDR;
    sel_msk = wb_i.adr == EMASK_ADDR;
    iir_busy = wb_i.cyc & wb_i.stb & ~wb_i.we & sel_iir;
    iir_rd = rd & sel_iir;
  end

  // ==========================================================
  // source levels, priority and timing figures
  always_comb begin
    act = rx_wr_i | rx_rd_i;
    dav_lvl = fifo_en_i ? (rx_count_i >= rx_trig_level_i) : (rx_count_i != '0);
    mchg = q.mvalid[1] & ((q.msync2.dcd ^ q.mprev.dcd) | (q.msync2.dsr ^ q.mprev.dsr)
           | (q.msync2.cts ^ q.mprev.cts) | (q.msync2.ri & ~q.mprev.ri));
    pend[0] = q.ier[IER_LERR_BIT] & q.line_err;
    pend[1] = q.ier[IER_DAV_BIT] & dav_lvl;
    pend[2] = q.ier[IER_DAV_BIT] & q.tmo;
    pend[3] = q.ier[IER_TXE_BIT] & q.txe_irq;
    pend[4] = q.ier[IER_MODEM_BIT] & q.modem_irq;
    // data available outranks time-out inside the shared second level
    if (pend[0]) begin
      live = {IIR_LERR, 1'b0};
    end else if (pend[1]) begin
      live = {IIR_DAV, 1'b0};
    end else if (pend[2]) begin
      live = {IIR_TMO, 1'b0};
    end else if (pend[3]) begin
      live = {IIR_TXE, 1'b0};
    end else if (pend[4]) begin
      live = {IIR_MODEM, 1'b0};
    end else begin
      live = IIR_SNAP_RST;
    end
    if (rx_trig_level_i > rx_count_i) begin
      trig_gap = CNT_W'(rx_trig_level_i - rx_count_i);
    end else begin
      trig_gap = '0;
    end
    cto_period = CNT_W'((CNT_W'(word_len_i) * CTO_WL_MUL - CTO_WL_SUB) * CTO_SCALE
                 + trig_gap * CTO_SCALE + CTO_ADD);
    // start bit plus data bits: one character less its stop bit
    txe_period = CNT_W'((CNT_W'(word_len_i) + 12'h001) * RCLK_PER_BIT);
  end

  // ==========================================================
  // register read mux; reserved bits read as zero
  always_comb begin
    rdat = 8'h00;
    if (sel_ier) begin
      rdat = {4'h0, q.ier};
    end else if (sel_iir) begin
      rdat = {{2{fifo_en_i}}, 2'b00, q.snap};
    end else if (sel_evt) begin
      rdat = {3'h0, q.evt};
    end else if (sel_msk) begin
      rdat = {3'h0, q.emask};
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    tmo_set = 1'b0;
    txe_set = 1'b0;
    d.ack = req;
    if (rd) begin
      d.dat = rdat;
    end
    if (wr && sel_ier) begin
      d.ier = wb_i.dat[IER_W-1:0];
    end
    if (!iir_busy) begin
      d.snap = live;
    end

    // modem pins: two-flop synchroniser, then change detect
    d.msync1 = modem_pins_i;
    d.msync2 = q.msync1;
    d.mprev = q.msync2;
    d.mvalid = {q.mvalid[0], 1'b1};

    if (line_status_rd_i) begin
      d.line_err = 1'b0;
    end
    if (|line_err_i) begin
      d.line_err = 1'b1;
    end
    if (modem_status_rd_i) begin
      d.modem_irq = 1'b0;
    end
    if (mchg) begin
      d.modem_irq = 1'b1;
    end

    // character time-out timer runs on receive ticks only
    if (act || rx_count_i == '0) begin
      d.tmo = 1'b0;
      d.cto_cnt = '0;
    end else if (rclk_tick_i && !q.tmo) begin
      if (q.cto_cnt + 12'h001 >= cto_period) begin
        tmo_set = 1'b1;
        d.tmo = 1'b1;
        d.cto_cnt = '0;
      end else begin
        d.cto_cnt = q.cto_cnt + 12'h001;
      end
    end

    // transmit empty: clear first so a same-cycle set wins
    if (tx_held_two_i) begin
      d.seen2 = 1'b1;
    end
    if (thr_wr_i || (iir_rd && q.snap == {IIR_TXE, 1'b0})) begin
      d.txe_irq = 1'b0;
    end
    if (!tx_empty_i) begin
      d.txe_done = 1'b0;
      d.txe_cnt = '0;
    end else if (!q.txe_done) begin
      if (q.seen2) begin
        txe_set = 1'b1;
      end else if (rclk_tick_i) begin
        if (q.txe_cnt + 12'h001 >= txe_period) begin
          txe_set = 1'b1;
        end else begin
          d.txe_cnt = q.txe_cnt + 12'h001;
        end
      end
    end
    if (txe_set) begin
      d.txe_irq = 1'b1;
      d.txe_done = 1'b1;
      d.seen2 = 1'b0;
      d.txe_cnt = '0;
    end

    // sticky event log, write one to clear, set wins
    d.dav_prev = dav_lvl;
    evt_set = '0;
    evt_set[EVT_LERR] = |line_err_i;
    evt_set[EVT_DAV] = dav_lvl & ~q.dav_prev;
    evt_set[EVT_TMO] = tmo_set;
    evt_set[EVT_TXE] = txe_set;
    evt_set[EVT_MODEM] = mchg;
    if (wr && sel_evt) begin
      d.evt = q.evt & ~wb_i.dat[EVT_W-1:0];
    end
    d.evt = d.evt | evt_set;
    if (wr && sel_msk) begin
      d.emask = wb_i.dat[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.dat};
  assign irq_o = ~live[0];
  assign evt_irq_o = |(q.evt & q.emask);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_modem_change;
    q.mvalid[1] && q.msync2.cts != q.mprev.cts;
  endsequence

  sequence s_rx_quiet;
    rx_count_i != '0 && !act;
  endsequence

  property p_dav_gate;
    !q.ier[IER_DAV_BIT] |-> (live[3:1] != IIR_DAV && live[3:1] != IIR_TMO) || live[0];
  endproperty
  a_dav_gate: assert property (p_dav_gate) else $error("data or timeout shown while masked");

  property p_txe_gate;
    (!q.ier[IER_TXE_BIT] && live[0] == 1'b0) |-> live[3:1] != IIR_TXE;
  endproperty
  a_txe_gate: assert property (p_txe_gate) else $error("tx empty reported while masked");

  property p_lerr_top;
    (q.ier[IER_LERR_BIT] && q.line_err) |-> live == {IIR_LERR, 1'b0};
  endproperty
  a_lerr_top: assert property (p_lerr_top) else $error("line error not top priority");

  property p_modem_low;
    (live == {IIR_MODEM, 1'b0}) |-> q.ier[IER_MODEM_BIT] && q.modem_irq && pend[3:0] == 4'h0;
  endproperty
  a_modem_low: assert property (p_modem_low) else $error("modem code without cause");

  property p_irq_pending;
    irq_o == (|pend);
  endproperty
  a_irq_pending: assert property (p_irq_pending) else $error("irq output disagrees");

  property p_iir_frozen;
    (iir_busy && !$past(rst_i)) ##1 iir_busy |-> $stable(q.snap);
  endproperty
  a_iir_frozen: assert property (p_iir_frozen) else $error("identify changed during read");

  property p_iir_fifo_bits;
    (req && !wb_i.we && sel_iir) |=> wb_ack_o && wb_dat_o[7:4] == {{2{$past(fifo_en_i)}}, 2'b00};
  endproperty
  a_iir_fifo_bits: assert property (p_iir_fifo_bits) else $error("identify fifo bits wrong");

  property p_lsr_clear;
    (line_status_rd_i && !(|line_err_i)) |=> !q.line_err;
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("line error not cleared");

  property p_tmo_cause;
    $rose(q.tmo) |-> $past(rx_count_i != '0 && !act && rclk_tick_i);
  endproperty
  a_tmo_cause: assert property (p_tmo_cause) else $error("time-out without quiet fifo");

  property p_activity_clear;
    act |=> !q.tmo && q.cto_cnt == '0;
  endproperty
  a_activity_clear: assert property (p_activity_clear) else $error("activity kept time-out");

  property p_thr_write_clear;
    (thr_wr_i && !tx_empty_i) |=> !q.txe_irq;
  endproperty
  a_thr_write_clear: assert property (p_thr_write_clear) else $error("tx empty survived write");

  property p_modem_raise;
    s_modem_change |=> q.modem_irq;
  endproperty
  a_modem_raise: assert property (p_modem_raise) else $error("modem change missed");

  property p_tmo_needs_quiet;
    s_rx_quiet ##1 act |=> !q.tmo;
  endproperty
  a_tmo_needs_quiet: assert property (p_tmo_needs_quiet) else $error("time-out not restarted");

endmodule // uie_irq_ident

// ---- tb/uie_cpu_model.sv ----
// processor side model: single classic wishbone cycles on request
// assumes callers enter xfer just after a rising edge of clk_i
`timescale 1ns/1ns
module uie_cpu_model (
  input wire logic clk_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  output uie_pkg::uie_wb_req_s wb_o
);
  import uie_pkg::*;
  initial wb_o = '0;
  // =====================================================
  // bus cycle; released adr, dat and we show inverted values, not the old ones
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    wb_o <= '{adr: adr, dat: {24'h0, wd}, sel: 4'h1, we: we, cyc: 1'b1, stb: 1'b1};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_i[7:0];
    wb_o <= '{adr: ~adr, dat: ~{24'h0, wd}, sel: 4'h0, we: ~we, cyc: 1'b0, stb: 1'b0};
    @(posedge clk_i);
  endtask
endmodule // uie_cpu_model

// ---- tb/uie_irq_ident_test.sv ----
// self-checking bench for the interrupt enable / identify block
// assumes word length 5 and a receive tick on every clock
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module uie_irq_ident_test;
  import uie_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  uie_wb_req_s wb;
  logic [31:0] wb_dat;
  logic wb_ack, irq, evt_irq;
  logic fifo_en = 0, line_rd = 0, modem_rd = 0, rx_wr = 0, rx_rd = 0;
  logic tx_empty = 0, held_two = 0, thr_wr = 0;
  uie_lerr_s lerr = '0;
  uie_modem_s pins = '0;
  logic [4:0] cnt = 0, trig = 1;
  int err_count = 0, compares = 0, cycles = 0;

  always #25 clk_i = ~clk_i;

  uie_cpu_model i_cpu (.clk_i(clk_i), .wb_dat_i(wb_dat), .wb_ack_i(wb_ack), .wb_o(wb));
  uie_irq_ident i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .divisor_access_select_i(1'b0), .fifo_en_i(fifo_en),
    .line_err_i(lerr), .line_status_rd_i(line_rd), .modem_pins_i(pins),
    .modem_status_rd_i(modem_rd), .rx_count_i(cnt), .rx_trig_level_i(trig),
    .rx_wr_i(rx_wr), .rx_rd_i(rx_rd), .rclk_tick_i(1'b1), .word_len_i(4'h5),
    .tx_empty_i(tx_empty), .tx_held_two_i(held_two), .thr_wr_i(thr_wr),
    .irq_o(irq), .evt_irq_o(evt_irq));

  // =====================================================
  // helpers
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the longest scenario
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [31:0] adr, input logic [7:0] d);
    logic [7:0] unused;
    i_cpu.xfer(1'b1, adr, d, unused);
  endtask

  task automatic chk_rd(input logic [31:0] adr, input logic [7:0] ex, input string nm);
    logic [7:0] d;
    i_cpu.xfer(1'b0, adr, 8'h00, d);
    `CHK(nm, ex, d)
  endtask

  // =====================================================
  // scenarios
  task automatic t_reset;
    chk_rd(IIR_ADDR, 8'h01, "ident_reset");
    chk_rd(IER_ADDR, 8'h00, "enable_reset");
    chk_rd(32'he0010030, 8'h00, "unmapped");
    wr(IIR_ADDR, 8'hff);
    chk_rd(IIR_ADDR, 8'h01, "ident_ro");
  endtask

  task automatic t_line;
    wr(IER_ADDR, 8'h0b);
    lerr.parity_error <= 1'b1;
    step(1);
    lerr <= '0;
    step(2);
    `CHK("irq_masked", 1'b0, irq)
    chk_rd(IIR_ADDR, 8'h01, "ident_masked");
    wr(IER_ADDR, 8'h0f);
    chk_rd(IER_ADDR, 8'h0f, "enable_rb");
    lerr.framing_error <= 1'b1;
    step(1);
    lerr <= '0;
    step(2);
    `CHK("irq_line", 1'b1, irq)
    chk_rd(IIR_ADDR, 8'h06, "ident_line");
    chk_rd(EVT_ADDR, 8'h01, "evt_line");
    `CHK("evt_irq_masked", 1'b0, evt_irq)
    wr(EMASK_ADDR, 8'h01);
    `CHK("evt_irq_on", 1'b1, evt_irq)
    wr(EVT_ADDR, 8'h01);
    `CHK("evt_irq_clr", 1'b0, evt_irq)
    line_rd <= 1'b1;
    step(1);
    line_rd <= 1'b0;
    step(2);
    chk_rd(IIR_ADDR, 8'h01, "ident_line_clr");
  endtask

  task automatic t_prio;
    cnt <= 5'd1;
    pins.cts <= 1'b1;
    step(6);
    chk_rd(IIR_ADDR, 8'h04, "ident_data_over_modem");
    wr(IER_ADDR, 8'h0e);
    chk_rd(IIR_ADDR, 8'h00, "ident_data_masked");
    cnt <= 5'd0;
    modem_rd <= 1'b1;
    step(1);
    modem_rd <= 1'b0;
    step(2);
    chk_rd(IIR_ADDR, 8'h01, "ident_modem_clr");
    wr(IER_ADDR, 8'h0f);
  endtask

  task automatic t_fifo;
    fifo_en <= 1'b1;
    trig <= 5'd2;
    cnt <= 5'd2;
    step(2);
    chk_rd(IIR_ADDR, 8'hc4, "ident_trig");
    cnt <= 5'd1;
    rx_wr <= 1'b1;
    step(1);
    rx_wr <= 1'b0;
    step(1);
    chk_rd(IIR_ADDR, 8'hc1, "ident_below_trig");
    step(240);
    `CHK("irq_before_timeout", 1'b0, irq)
    step(40);
    chk_rd(IIR_ADDR, 8'hcc, "ident_timeout");
    rx_rd <= 1'b1;
    step(1);
    rx_rd <= 1'b0;
    step(2);
    chk_rd(IIR_ADDR, 8'hc1, "ident_timeout_clr");
    cnt <= 5'd0;
    fifo_en <= 1'b0;
    step(2);
  endtask

  task automatic t_txe;
    wr(IER_ADDR, 8'h02);
    held_two <= 1'b1;
    step(1);
    held_two <= 1'b0;
    tx_empty <= 1'b1;
    step(3);
    chk_rd(IIR_ADDR, 8'h02, "ident_txe");
    chk_rd(IIR_ADDR, 8'h01, "ident_txe_rd_clr");
    held_two <= 1'b1;
    tx_empty <= 1'b0;
    step(1);
    held_two <= 1'b0;
    tx_empty <= 1'b1;
    step(3);
    `CHK("irq_txe", 1'b1, irq)
    thr_wr <= 1'b1;
    step(1);
    thr_wr <= 1'b0;
    step(2);
    `CHK("irq_txe_wr_clr", 1'b0, irq)
  endtask

  // =====================================================
  // main sequence
  initial begin
    step(2);
    rst_i <= 1'b0;
    step(1);
    t_reset();
    t_line();
    t_prio();
    t_fifo();
    t_txe();
    end_sim();
  end
endmodule // uie_irq_ident_test
